// ===== dv/brake_stop_sequencer_tb.sv
// self-checking bench for the brake and stop sequencer
// assumes converter_model on the far side and a 100 MHz clock
`timescale 1ns/1ps
module brake_stop_sequencer_tb
  import brake_stop_pkg::*;
;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
  note_t q[$];
  note_t n;
  int error_cnt = 0, checked = 0;
  logic clk = 1'b0, rst = 1'b1, pwr_fail = 1'b0, brake_req = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, x = 32'hf4b8;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic forward_start_input = 0, reverse_start_input = 0, output_enable_input = 1, output_stop_input = 0;
  logic converter_ready, special_stop = 0, motor_stopped, brake_on, decelerating;
  logic [15:0] freq_command = '0, stall_prevention_level = '0, carrier_frequency_selection = '0;
  logic drive_on, decel_cmd, dir_reverse, motor_active, speed_search, start_from_min, regen_duty_alarm;
  logic regen_duty_indicator, alarm_terminal, regen_overvoltage_fault_accel, regen_overvoltage_fault_decel;
  logic excitation_comp;
  int sfm_cnt = 0, srch_cnt = 0;
  logic [15:0] freq_out, stall_level_out, excitation_out, carrier_out;

  brake_stop_sequencer #(.SEC_CYC(10), .DUTY_CYC(8)) brake_stop_sequencer_inst (.clk, .rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .forward_start_input,
    .reverse_start_input, .output_enable_input, .output_stop_input, .converter_ready, .special_stop,
    .motor_stopped, .brake_on, .decelerating, .freq_command, .stall_prevention_level,
    .carrier_frequency_selection, .drive_on, .decel_cmd, .dir_reverse, .motor_active, .speed_search,
    .start_from_min, .regen_duty_alarm, .regen_duty_indicator, .alarm_terminal,
    .regen_overvoltage_fault_accel, .regen_overvoltage_fault_decel, .freq_out, .stall_level_out,
    .excitation_out, .excitation_comp, .carrier_out);
  converter_model converter_model_inst (.clk, .rst, .pwr_fail, .brake_req, .drive_on, .decel_cmd,
    .converter_ready, .motor_stopped, .brake_on, .decelerating);

  always #5 clk = ~clk;

  // fresh random setpoints every cycle
  always @(posedge clk) begin
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    freq_command <= x[15:0];
    stall_prevention_level <= x[31:16];
    carrier_frequency_selection <= {12'h0, x[3:0]};
  end

  // oldest note is compared whenever a response is taken
  always @(posedge clk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      n = q.pop_front();
      checked++;
      if (s_axi_rvalid ? ((s_axi_rdata & n.m) !== n.d || s_axi_rresp !== n.r) : s_axi_bresp !== n.r) begin
        error_cnt++;
        $display("BAD %0t response differs, expected %h", $time, n.d);
      end
    end
  end

  // restart pulses are counted for the closing checks
  always @(posedge clk) begin
    if (!rst) begin
      sfm_cnt <= sfm_cnt + start_from_min;
      srch_cnt <= srch_cnt + speed_search;
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // direct look at a settled output level
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t output %h expected %h", $time, g, e);
    end
  endtask

  // one bus transfer, write or read, with its expected answer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] r);
    int i;
    q.push_back('{d & m, m, r});
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w ? s_axi_bvalid : s_axi_rvalid) break;
    end
    if (i == 40) begin
      error_cnt++;
      $display("BAD %0t no bus answer", $time);
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 2'b00);
  endtask

  task automatic st(input logic [31:0] d, input logic [31:0] m, input int wt);
    repeat (wt) @(posedge clk);
    xfer(1'b0, OFS_STATUS, d, m, 2'b00);
  endtask

  // main sequence: defaults, stop modes, shutoffs, brake duty
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, OFS_STOP_SEL, 32'd9999, 32'hffff, 2'b00);
    xfer(1'b0, OFS_CONTACT, 32'd0, 32'hffff, 2'b00);
    xfer(1'b0, OFS_LOW_SPEED, 32'd10, 32'hffff, 2'b00);
    xfer(1'b0, OFS_STALL2, 32'd9999, 32'hffff, 2'b00);
    xfer(1'b0, OFS_EXCITE, 32'd9999, 32'hffff, 2'b00);
    xfer(1'b0, OFS_CARRIER, 32'd9999, 32'hffff, 2'b00);
    xfer(1'b0, 8'h2c, 32'h0, 32'h0, 2'b10);
    forward_start_input <= 1'b1;
    st(32'h23, 32'hfb, 4);
    forward_start_input <= 1'b0;
    st(32'h43, 32'hfb, 2);
    ck(decel_cmd, 1'b1);
    ck(dir_reverse, 1'b0);
    st(32'h00, 32'hfb, 12);
    wr(OFS_STOP_SEL, 32'd1002);
    forward_start_input <= 1'b1;
    reverse_start_input <= 1'b1;
    repeat (4) @(posedge clk);
    forward_start_input <= 1'b0;
    st(32'h63, 32'hfb, 12);
    ck(dir_reverse, 1'b1);
    st(32'h80, 32'hfb, 10);
    forward_start_input <= 1'b1;
    st(32'h23, 32'hfb, 4);
    pwr_fail <= 1'b1;
    st(32'h00, 32'h03, 3);
    pwr_fail <= 1'b0;
    st(32'h03, 32'h03, 3);
    output_enable_input <= 1'b0;
    forward_start_input <= 1'b0;
    st(32'h00, 32'h03, 3);
    output_enable_input <= 1'b1;
    forward_start_input <= 1'b1;
    st(32'h03, 32'h03, 4);
    output_stop_input <= 1'b1;
    st(32'h00, 32'h03, 3);
    output_stop_input <= 1'b0;
    wr(OFS_REGEN_SEL, 32'd1);
    wr(OFS_DUTY_LIM, 32'd10);
    wr(OFS_TERM_FUNC, 32'd107);
    brake_req <= 1'b1;
    st(32'h03, 32'h1f, 60);
    ck(alarm_terminal, 1'b1);
    ck(regen_duty_indicator, 1'b0);
    st(32'h07, 32'h1f, 8);
    st(32'h0c, 32'h1f, 15);
    ck(regen_duty_indicator, 1'b1);
    ck(alarm_terminal, 1'b0);
    wr(OFS_CONTACT, 32'd1);
    wr(OFS_STALL2, 32'd150);
    wr(OFS_EXCITE, 32'd150);
    wr(OFS_CARRIER, 32'd5);
    wr(OFS_REGEN_SEL, 32'd2);
    wr(OFS_DUTY_LIM, 32'd0);
    wr(OFS_FAULT_CLR, 32'd1);
    ck(freq_out, 32'd10);
    ck(stall_level_out, 32'd150);
    ck(excitation_out, 32'd150);
    ck(excitation_comp, 1'b1);
    ck(carrier_out, 32'd5);
    st(32'h00, 32'h1c, 2);
    ck(sfm_cnt, 32'd4);
    ck(srch_cnt, 32'd1);
    wrap_up();
  end
endmodule // brake_stop_sequencer_tb

// ===== dv/converter_model.sv
// far side: power converter, motor load and brake transistor
// assumes sequencer outputs on the same clock
`timescale 1ns/1ps
module converter_model #(
  parameter int STOP_CNT = 40
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pwr_fail,
  input  wire logic brake_req,
  input  wire logic drive_on,
  input  wire logic decel_cmd,
  output logic      converter_ready,
  output logic      motor_stopped,
  output logic      brake_on,
  output logic      decelerating
);
  int cnt;
  // motor slows fast under decel, slowly when coasting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt <= 0;
    else if (drive_on && !decel_cmd) cnt <= 0;
    else if (cnt < STOP_CNT) cnt <= cnt + (decel_cmd ? 5 : 1);
  end
  // ready flags a power loss; brake fires on request
  assign converter_ready = pwr_fail;
  assign motor_stopped   = (cnt >= STOP_CNT);
  assign brake_on        = brake_req;
  assign decelerating    = decel_cmd;
endmodule // converter_model

// ===== inc/brake_stop_pkg.sv
// constants shared by the brake and stop sequencer
// assumes a 100 MHz clock and a 32-bit AXI4-Lite register port
package brake_stop_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_REGEN_SEL  = 8'h00;
  localparam logic [7:0] OFS_DUTY_LIM   = 8'h04;
  localparam logic [7:0] OFS_STOP_SEL   = 8'h08;
  localparam logic [7:0] OFS_TERM_FUNC  = 8'h0c;
  localparam logic [7:0] OFS_CONTACT    = 8'h10;
  localparam logic [7:0] OFS_LOW_SPEED  = 8'h14;
  localparam logic [7:0] OFS_STALL2     = 8'h18;
  localparam logic [7:0] OFS_EXCITE     = 8'h1c;
  localparam logic [7:0] OFS_CARRIER    = 8'h20;
  localparam logic [7:0] OFS_STATUS     = 8'h24;
  localparam logic [7:0] OFS_FAULT_CLR  = 8'h28;
  // reset values
  localparam logic [15:0] RST_STOP_SEL  = 16'h270f; // 9999
  localparam logic [15:0] RST_LOW_SPEED = 16'h000a; // 10 Hz
  localparam logic [15:0] RST_UNUSED    = 16'h270f; // 9999
  // special codes
  localparam logic [15:0] CODE_UNUSED   = 16'h270f; // 9999
  localparam logic [15:0] CODE_DECEL2   = 16'h22b8; // 8888
  localparam logic [15:0] CODE_TMAX     = 16'h0064; // 100 s
  localparam logic [15:0] CODE_SD_LO    = 16'h03e8; // 1000
  localparam logic [15:0] CODE_SD_HI    = 16'h044c; // 1100
  localparam logic [7:0]  TERM_ALARM_HI = 8'h07;    // 7
  localparam logic [7:0]  TERM_ALARM_LO = 8'h6b;    // 107
  localparam logic [15:0] MAX_LOW_SPEED = 16'h0190; // 400 Hz
  localparam logic [15:0] MAX_STALL2    = 16'h00c8; // 200 %
  localparam logic [15:0] MAX_EXCITE    = 16'h012c; // 300 %
  localparam logic [15:0] MAX_CARRIER   = 16'h0009; // code 9
  localparam logic [15:0] MAX_DUTY      = 16'h001e; // 30 %
  localparam logic [7:0]  FIXED_DUTY    = 8'h02;    // built-in 2 %
  localparam int ALARM_NUM = 85; // alarm at 85 % of limit
  localparam int ALARM_DEN = 100;
  // timing
  localparam int CLK_HZ     = 100_000_000;
  localparam int SEC_CYCLES = CLK_HZ * 1; // one second in cycles
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RUN   = 3'b001,
    ST_DECEL = 3'b010,
    ST_DELAY = 3'b011,
    ST_COAST = 3'b100
  } seq_state_t;
endpackage

// ===== rtl/brake_stop_sequencer.sv
// brake duty supervision, stop sequencing and contact-stop setup
// assumes synchronous inputs, one clock, AXI4-Lite master outside
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// - converter ready while running: coast, then speed-search restart
// - indicator and alarm at 85 % of limit
// - overvoltage fault at 100 % of limit
// - no indicator while select equals 0
// - alarm alone never stops output
// - alarm pin routed by code 7 or 107
// - output stop input shuts output off alongside enable input
// - 0..100 s: direction starts, timed shutoff
// - 1000..1100: start plus direction, setting-1000 s
// - 9999 or 8888: decelerate on start drop
// - motor active drops with output shutoff
// - special stops override stop selection timing
// - timed modes follow frequency command meanwhile
// - restart from coast at starting frequency
// - contact select 0 normal, 1 contact, reset 0
// - contact frequency from low-speed preset, 10 Hz
// - second stall level, 9999 uses normal level
// - excitation multiplier, 9999 means no compensation
// - contact carrier code, 9999 uses normal selection
// - select 0 applies built-in fixed duty
// - enable input low shuts drive output off
module brake_stop_sequencer
  import brake_stop_pkg::*;
#(
  parameter int SEC_CYC  = SEC_CYCLES,
  parameter int DUTY_CYC = 1000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        forward_start_input,
  input  wire logic        reverse_start_input,
  input  wire logic        output_enable_input,
  input  wire logic        output_stop_input,
  input  wire logic        converter_ready,
  input  wire logic        special_stop,
  input  wire logic        motor_stopped,
  input  wire logic        brake_on,
  input  wire logic        decelerating,
  input  wire logic [15:0] freq_command,
  input  wire logic [15:0] stall_prevention_level,
  input  wire logic [15:0] carrier_frequency_selection,
  output logic             drive_on,
  output logic             decel_cmd,
  output logic             dir_reverse,
  output logic             motor_active,
  output logic             speed_search,
  output logic             start_from_min,
  output logic             regen_duty_alarm,
  output logic             regen_duty_indicator,
  output logic             alarm_terminal,
  output logic             regen_overvoltage_fault_accel,
  output logic             regen_overvoltage_fault_decel,
  output logic [15:0]      freq_out,
  output logic [15:0]      stall_level_out,
  output logic [15:0]      excitation_out,
  output logic             excitation_comp,
  output logic [15:0]      carrier_out
);

  // configuration registers
  logic [1:0]  regen_function_select_reg;
  logic [15:0] special_regen_duty_limit_reg;
  logic [15:0] stop_selection_reg;
  logic [7:0]  output_terminal_function_reg;
  logic        stop_on_contact_select_reg;
  logic [15:0] low_speed_preset_reg;
  logic [15:0] second_stall_level_reg;
  logic [15:0] contact_excitation_multiplier_reg;
  logic [15:0] contact_carrier_setting_reg;

  // bus handshake state
  logic       wr_go_reg;
  logic       rd_go_reg;
  logic [7:0] rd_addr_reg;

  // write address decode and value range checks
  wire        wr_take  = s_axi_awvalid & s_axi_wvalid & ~wr_go_reg & ~s_axi_bvalid;
  wire        wr_full  = s_axi_wstrb == 4'hf;
  wire [15:0] wv       = s_axi_wdata[15:0];
  wire        in_range = (wv <= MAX_DUTY);
  wire        sel_ok   = (wv[15:2] == 14'h0) & (wv[1:0] != 2'b11);
  wire        stop_ok  = (wv <= CODE_TMAX) | (wv == CODE_UNUSED) | (wv == CODE_DECEL2)
                       | (wv >= CODE_SD_LO & wv <= CODE_SD_HI);
  wire        we       = wr_go_reg & wr_full;
  wire [7:0]  wa       = s_axi_awaddr;
  wire        wa_known = (wa <= OFS_FAULT_CLR) & (wa[1:0] == 2'b00) & (wa != OFS_STATUS);
  wire        fault_clear = we & (wa == OFS_FAULT_CLR) & s_axi_wdata[0];

  // software writes; out-of-range values leave the old setting, except terminal function and contact keep their low bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regen_function_select_reg         <= 2'h0;
      special_regen_duty_limit_reg      <= 16'h0;
      stop_selection_reg                <= RST_STOP_SEL;
      output_terminal_function_reg      <= 8'h0;
      stop_on_contact_select_reg        <= 1'b0;
      low_speed_preset_reg              <= RST_LOW_SPEED;
      second_stall_level_reg            <= RST_UNUSED;
      contact_excitation_multiplier_reg <= RST_UNUSED;
      contact_carrier_setting_reg       <= RST_UNUSED;
    end else if (we) begin
      case (wa)
        OFS_REGEN_SEL: if (sel_ok) regen_function_select_reg <= wv[1:0];
        OFS_DUTY_LIM:  if (in_range) special_regen_duty_limit_reg <= wv;
        OFS_STOP_SEL:  if (stop_ok) stop_selection_reg <= wv;
        OFS_TERM_FUNC: output_terminal_function_reg <= s_axi_wdata[7:0];
        OFS_CONTACT:   stop_on_contact_select_reg <= s_axi_wdata[0];
        OFS_LOW_SPEED: if (wv <= MAX_LOW_SPEED) low_speed_preset_reg <= wv;
        OFS_STALL2:    if (wv <= MAX_STALL2 | wv == CODE_UNUSED) second_stall_level_reg <= wv;
        OFS_EXCITE:    if (wv <= MAX_EXCITE | wv == CODE_UNUSED) contact_excitation_multiplier_reg <= wv;
        OFS_CARRIER:   if (wv <= MAX_CARRIER | wv == CODE_UNUSED) contact_carrier_setting_reg <= wv;
        default: ;
      endcase
    end
  end

  // write channel: take address and data together, answer next cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_go_reg    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      wr_go_reg <= wr_take;
      if (wr_go_reg) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_known ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ready pulses are the registered take
  always_comb begin
    s_axi_awready = wr_go_reg;
    s_axi_wready  = wr_go_reg;
  end

  // sequencer and duty state
  seq_state_t  state_reg, state_next;
  logic [31:0] cyc_reg;
  logic [15:0] sec_reg;
  logic [31:0] acc_reg;
  logic        search_pend_reg;

  // status word
  wire [31:0] status_word = {acc_reg[15:0], 7'h0, search_pend_reg, state_reg,
                             regen_overvoltage_fault_decel, regen_overvoltage_fault_accel,
                             regen_duty_alarm, motor_active, drive_on};

  // read data selection
  logic [31:0] rd_mux;
  always_comb begin
    case (rd_addr_reg)
      OFS_REGEN_SEL: rd_mux = {30'h0, regen_function_select_reg};
      OFS_DUTY_LIM:  rd_mux = {16'h0, special_regen_duty_limit_reg};
      OFS_STOP_SEL:  rd_mux = {16'h0, stop_selection_reg};
      OFS_TERM_FUNC: rd_mux = {24'h0, output_terminal_function_reg};
      OFS_CONTACT:   rd_mux = {31'h0, stop_on_contact_select_reg};
      OFS_LOW_SPEED: rd_mux = {16'h0, low_speed_preset_reg};
      OFS_STALL2:    rd_mux = {16'h0, second_stall_level_reg};
      OFS_EXCITE:    rd_mux = {16'h0, contact_excitation_multiplier_reg};
      OFS_CARRIER:   rd_mux = {16'h0, contact_carrier_setting_reg};
      OFS_STATUS:    rd_mux = status_word;
      default:       rd_mux = 32'h0;
    endcase
  end
  wire rd_known = (rd_addr_reg <= OFS_STATUS) & (rd_addr_reg[1:0] == 2'b00);

  // read channel: take address, data one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_go_reg     <= 1'b0;
      rd_addr_reg   <= 8'h0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else begin
      rd_go_reg <= s_axi_arvalid & ~rd_go_reg & ~s_axi_rvalid;
      if (s_axi_arvalid & ~rd_go_reg & ~s_axi_rvalid) rd_addr_reg <= s_axi_araddr;
      if (rd_go_reg) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_known ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  always_comb s_axi_arready = rd_go_reg;

  // start decoding by stop selection
  wire [15:0] ss       = stop_selection_reg;
  wire        sd_mode  = (ss >= CODE_SD_LO) & (ss <= CODE_SD_HI);
  wire        dir_mode = (ss <= CODE_TMAX) | (ss == CODE_UNUSED);
  wire        timed    = ((ss <= CODE_TMAX) | sd_mode) & ~special_stop;
  wire [15:0] delay_s  = sd_mode ? ss - CODE_SD_LO : ss;
  wire        start    = dir_mode ? (forward_start_input ^ reverse_start_input)
                                  : forward_start_input;
  wire        want_rev = dir_mode ? reverse_start_input : reverse_start_input;
  wire        enabled  = output_enable_input & ~output_stop_input;
  wire        tripped  = regen_overvoltage_fault_accel | regen_overvoltage_fault_decel;
  wire        kill     = ~enabled | tripped | converter_ready;
  wire        sec_tick = (cyc_reg == 32'(SEC_CYC - 1));
  wire        delay_up = (sec_reg >= delay_s);

  // next-state logic of the stop sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (start & ~kill) state_next = ST_RUN;
      ST_RUN: begin
        if (kill) state_next = ST_COAST;
        else if (~start) state_next = timed ? ST_DELAY : ST_DECEL;
      end
      ST_DECEL: begin
        if (kill) state_next = ST_COAST;
        else if (start) state_next = ST_RUN;
        else if (motor_stopped) state_next = ST_IDLE;
      end
      ST_DELAY: begin
        if (kill | delay_up) state_next = ST_COAST;
        else if (start) state_next = ST_RUN;
      end
      ST_COAST: begin
        if (~kill & (start | search_pend_reg)) state_next = ST_RUN;
        else if (motor_stopped & ~search_pend_reg) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // state register and shutoff delay timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cyc_reg   <= 32'h0;
      sec_reg   <= 16'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg != ST_DELAY) begin
        cyc_reg <= 32'h0;
        sec_reg <= 16'h0;
      end else if (sec_tick) begin
        cyc_reg <= 32'h0;
        sec_reg <= sec_reg + 16'h1;
      end else begin
        cyc_reg <= cyc_reg + 32'h1;
      end
    end
  end

  // drive control outputs follow the next state
  wire run_next = (state_next == ST_RUN) | (state_next == ST_DECEL) | (state_next == ST_DELAY);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_on        <= 1'b0;
      motor_active    <= 1'b0;
      decel_cmd       <= 1'b0;
      dir_reverse     <= 1'b0;
      speed_search    <= 1'b0;
      start_from_min  <= 1'b0;
      search_pend_reg <= 1'b0;
    end else begin
      drive_on     <= run_next;
      motor_active <= run_next;
      decel_cmd    <= state_next == ST_DECEL;
      if (state_next == ST_RUN & state_reg != ST_RUN) dir_reverse <= want_rev;
      // converter ready during running arms a speed search
      if (state_reg == ST_RUN & converter_ready & enabled & ~tripped) search_pend_reg <= 1'b1;
      else if (state_next == ST_RUN | ~enabled | tripped) search_pend_reg <= 1'b0;
      speed_search   <= state_reg == ST_COAST & state_next == ST_RUN & search_pend_reg;
      start_from_min <= state_reg == ST_COAST & state_next == ST_RUN & ~search_pend_reg;
    end
  end

  // duty limit in accumulator units
  wire [7:0]  duty_pct = (regen_function_select_reg == 2'h0) ? FIXED_DUTY
                       : special_regen_duty_limit_reg[7:0];
  wire [31:0] limit    = 32'(duty_pct) * 32'(DUTY_CYC);
  wire        hit_full = (limit != 32'h0) & (acc_reg >= limit);
  wire        hit_warn = (limit != 32'h0) &
                         (acc_reg * 32'(ALARM_DEN) >= limit * 32'(ALARM_NUM));

  // brake duty accumulator: rises while braking, decays otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= 32'h0;
    end else if (brake_on) begin
      if (~hit_full) acc_reg <= acc_reg + 32'h1;
    end else if (acc_reg != 32'h0) begin
      acc_reg <= acc_reg - 32'h1;
    end
  end

  // alarm, indicator, terminal and latched faults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regen_duty_alarm              <= 1'b0;
      regen_duty_indicator          <= 1'b0;
      alarm_terminal                <= 1'b0;
      regen_overvoltage_fault_accel <= 1'b0;
      regen_overvoltage_fault_decel <= 1'b0;
    end else begin
      regen_duty_alarm     <= hit_warn;
      regen_duty_indicator <= hit_warn & (regen_function_select_reg != 2'h0);
      case (output_terminal_function_reg)
        TERM_ALARM_HI: alarm_terminal <= hit_warn;
        TERM_ALARM_LO: alarm_terminal <= ~hit_warn;
        default:       alarm_terminal <= 1'b0;
      endcase
      // a new trip in the clear cycle wins
      if (hit_full & ~decelerating) regen_overvoltage_fault_accel <= 1'b1;
      else if (fault_clear) regen_overvoltage_fault_accel <= 1'b0;
      if (hit_full & decelerating) regen_overvoltage_fault_decel <= 1'b1;
      else if (fault_clear) regen_overvoltage_fault_decel <= 1'b0;
    end
  end

  // stop-on-contact setting selection
  wire soc = stop_on_contact_select_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_out        <= 16'h0;
      stall_level_out <= 16'h0;
      excitation_out  <= 16'h0;
      excitation_comp <= 1'b0;
      carrier_out     <= 16'h0;
    end else begin
      freq_out <= soc ? low_speed_preset_reg : freq_command;
      stall_level_out <= (soc & second_stall_level_reg != CODE_UNUSED)
                         ? second_stall_level_reg : stall_prevention_level;
      excitation_comp <= soc & contact_excitation_multiplier_reg != CODE_UNUSED;
      excitation_out  <= contact_excitation_multiplier_reg;
      carrier_out <= (soc & contact_carrier_setting_reg != CODE_UNUSED)
                     ? contact_carrier_setting_reg : carrier_frequency_selection;
    end
  end

  // checks
  a_kill_stops_drive: assert property (@(posedge clk) disable iff (rst)
    ~enabled |=> ~drive_on) else $error("drive stays on without enable");
  a_active_tracks_drive: assert property (@(posedge clk) disable iff (rst)
    motor_active == drive_on) else $error("motor active differs from drive");
  a_decel_on_drop: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_RUN & ~start & ~timed & ~kill |=> decel_cmd & drive_on)
    else $error("no decel after start drop");
  a_timed_no_decel: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_RUN & ~start & timed & ~kill |=> ~decel_cmd & state_reg == ST_DELAY)
    else $error("timed stop decelerates");
  a_alarm_no_trip: assert property (@(posedge clk) disable iff (rst)
    hit_warn & ~hit_full & ~tripped |=> ~regen_overvoltage_fault_accel & ~regen_overvoltage_fault_decel)
    else $error("alarm alone tripped");
  a_fault_on_full: assert property (@(posedge clk) disable iff (rst)
    hit_full |=> tripped) else $error("no fault at full duty");
  a_indicator_hidden: assert property (@(posedge clk) disable iff (rst)
    regen_function_select_reg == 2'h0 |=> ~regen_duty_indicator) else $error("indicator shown at select 0");
  a_terminal_polarity: assert property (@(posedge clk) disable iff (rst)
    output_terminal_function_reg == TERM_ALARM_LO & $stable(output_terminal_function_reg)
    |=> alarm_terminal == ~regen_duty_alarm) else $error("negative alarm terminal wrong");
  a_contact_freq: assert property (@(posedge clk) disable iff (rst)
    soc |=> freq_out == $past(low_speed_preset_reg))
    else $error("contact frequency not preset");
  a_coast_on_ready: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_RUN & converter_ready |=> ~drive_on & (search_pend_reg | ~$past(enabled) | $past(tripped)))
    else $error("no coast on converter ready");
  c_timed_stop: cover property (@(posedge clk) disable iff (rst)
    state_reg == ST_DELAY ##1 state_reg == ST_COAST);
  c_decel_stop: cover property (@(posedge clk) disable iff (rst)
    state_reg == ST_DECEL ##1 state_reg == ST_IDLE);
  c_speed_search: cover property (@(posedge clk) disable iff (rst) speed_search);
  c_alarm_seen: cover property (@(posedge clk) disable iff (rst) regen_duty_alarm);

endmodule // brake_stop_sequencer
